// ### ipd_pkg.sv
package ipd_pkg;

	// register byte offsets
	localparam logic [7:0] IPD_POWER_CONTROL_REGISTER_OFFS = 8'h00;
	localparam logic [7:0] IPD_STAT_OFFS = 8'h04;

	// power_control_register field positions
	localparam int IPD_IDLE_BIT = 0;
	localparam int IPD_PD_BIT = 1;
	localparam int IPD_GF0_BIT = 2;
	localparam int IPD_GF1_BIT = 3;
	localparam logic [3:0] IPD_POWER_CONTROL_REGISTER_RST = 4'h0;

	// status register field positions
	localparam int IPD_STAT_MODE_LSB = 0;
	localparam int IPD_STAT_RAMBLK_BIT = 8;

	// synchroniser reset image {rst, kbd, irq1_n, irq0_n}
	localparam logic [3:0] IPD_SYNC_RST = 4'h3;

	// oscillator settle time before clocks come back
	localparam int IPD_CLK_PERIOD_NS = 10;
	localparam int IPD_OSC_STABLE_NS = 1000;
	localparam int IPD_OSC_STABLE_CYC = (IPD_OSC_STABLE_NS + IPD_CLK_PERIOD_NS - 1)
		/ IPD_CLK_PERIOD_NS;

	localparam logic [1:0] IPD_RESP_OKAY = 2'h0;
	localparam logic [1:0] IPD_RESP_SLVERR = 2'h2;

	typedef enum logic [4:0] {
		IPD_ST_RUN = 5'h01,
		IPD_ST_IDLE = 5'h02,
		IPD_ST_PD = 5'h04,
		IPD_ST_STAB = 5'h08,
		IPD_ST_HOLD = 5'h10
	} ipd_mode_e;

	typedef enum logic [1:0] {
		IPD_SEL_POWER_CONTROL_REGISTER = 2'h0,
		IPD_SEL_STAT = 2'h1,
		IPD_SEL_NONE = 2'h2
	} ipd_sel_e;

endpackage

// ### ipd_pin_if.sv
`timescale 1ns/10ps
interface ipd_pin_if;
	logic ext_irq_0_n_raw;
	logic ext_irq_1_n_raw;
	logic kbd_raw;
	logic rst_raw;
	logic ext_irq_0_n;
	logic ext_irq_1_n;
	logic kbd;
	logic rst;

	modport sync (
		input ext_irq_0_n_raw,
		input ext_irq_1_n_raw,
		input kbd_raw,
		input rst_raw,
		output ext_irq_0_n,
		output ext_irq_1_n,
		output kbd,
		output rst
	);

	modport user (
		output ext_irq_0_n_raw,
		output ext_irq_1_n_raw,
		output kbd_raw,
		output rst_raw,
		input ext_irq_0_n,
		input ext_irq_1_n,
		input kbd,
		input rst
	);
endinterface

// ### ipd_pin_sync.sv
`timescale 1ns/10ps
module ipd_pin_sync
	import ipd_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_reset_n,
	ipd_pin_if.sync pins
);

	typedef struct packed {
		logic [3:0] stage1;
		logic [3:0] stage2;
	} ipd_sync_s;

	ipd_sync_s sync_reg;
	ipd_sync_s sync_next;

	always_comb begin
		sync_next.stage1 = {pins.rst_raw, pins.kbd_raw, pins.ext_irq_1_n_raw,
			pins.ext_irq_0_n_raw};
		sync_next.stage2 = sync_reg.stage1;
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sync_reg <= {IPD_SYNC_RST, IPD_SYNC_RST};
		end else begin
			sync_reg <= sync_next;
		end
	end

	assign pins.ext_irq_0_n = sync_reg.stage2[0];
	assign pins.ext_irq_1_n = sync_reg.stage2[1];
	assign pins.kbd = sync_reg.stage2[2];
	assign pins.rst = sync_reg.stage2[3];

endmodule

// ### ipd_power_ctrl.sv
`timescale 1ns/10ps
// Summary of operation
// - idle request takes effect when the setting instruction completes
// - idle stops the cpu clock only; peripherals and interrupts keep running
// - idle keeps pc, status word, special registers and ram unchanged
// - idle and power-down together give power-down only, no idle after
// - enabled interrupt in idle clears idle bit and restarts cpu clock
// - reset pin restores cpu clock at once, clears idle bit after the two-stage synchroniser
// - after reset-pin wake, ram is blocked while ports stay usable
// - power-down stops oscillator, freezes all clocks, keeps all state
// - power-down request takes effect when the setting instruction completes
// - enabled external interrupt wakes power-down; run resumes after release
// - interrupt wake leaves special registers and ram untouched
// - reset pin in power-down clears bit, restarts oscillator and clocks
// - enabled keyboard interrupt wakes power-down like an external interrupt
// - pin states per mode for port 0, other ports and strobes
// - control register: idle bit 0, power-down bit 1, flags bits 2-3
// - power-down bit cleared by hardware on any interrupt or reset
module ipd_power_ctrl
	import ipd_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int OSC_STABLE_CYC = IPD_OSC_STABLE_CYC
) (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	// axi4-lite slave
	input wire logic [ADDR_W-1:0] i_s_axi_awaddr,
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	output logic [1:0] o_s_axi_bresp,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	input wire logic [ADDR_W-1:0] i_s_axi_araddr,
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	// cpu core and interrupt logic, same clock
	input wire logic i_instr_done,
	input wire logic i_irq_pending,
	input wire logic [1:0] i_ext_irq_en,
	input wire logic i_kbd_irq_en,
	input wire logic i_ext_code,
	input wire logic i_ale_core,
	input wire logic i_program_store_strobe_n_core,
	// pins
	input wire logic i_ext_irq_0_n,
	input wire logic i_ext_irq_1_n,
	input wire logic i_kbd_irq,
	input wire logic i_rst_pin,
	// clock gating and pin control
	output logic o_cpu_clk_en,
	output logic o_periph_clk_en,
	output logic o_osc_en,
	output logic o_ram_block,
	output logic o_port0_float,
	output logic o_ports_high,
	output logic o_ale,
	output logic o_program_store_strobe_n,
	output logic [3:0] o_power_control_register
);

	initial begin
		if (ADDR_W < 3 || ADDR_W > 32) begin
			$error("ADDR_W must lie in 3..32");
		end
		if (OSC_STABLE_CYC < 1 || OSC_STABLE_CYC > 65535) begin
			$error("OSC_STABLE_CYC must lie in 1..65535");
		end
	end

	typedef struct packed {
		ipd_mode_e mode;
		logic [3:0] power_control_register;
		logic ram_block;
		logic [15:0] stab_cnt;
		logic aw_got;
		logic [ADDR_W-1:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} ipd_state_s;

	localparam logic [15:0] STAB_LAST = 16'(OSC_STABLE_CYC - 1);

	ipd_state_s state_reg;
	ipd_state_s state_next;
	ipd_pin_if pins ();

	logic wake_sync;
	logic wake_async;
	logic aw_hs;
	logic w_hs;
	logic ar_hs;
	logic do_write;
	ipd_sel_e wr_sel;

	function automatic ipd_sel_e decode_reg(input logic [ADDR_W-1:0] addr);
		ipd_sel_e sel;
		sel = IPD_SEL_NONE;
		if (addr == ADDR_W'(IPD_POWER_CONTROL_REGISTER_OFFS)) begin
			sel = IPD_SEL_POWER_CONTROL_REGISTER;
		end else if (addr == ADDR_W'(IPD_STAT_OFFS)) begin
			sel = IPD_SEL_STAT;
		end
		return sel;
	endfunction

	assign pins.ext_irq_0_n_raw = i_ext_irq_0_n;
	assign pins.ext_irq_1_n_raw = i_ext_irq_1_n;
	assign pins.kbd_raw = i_kbd_irq;
	assign pins.rst_raw = i_rst_pin;

	ipd_pin_sync u_sync (
		.i_mclk(i_mclk),
		.i_reset_n(i_reset_n),
		.pins(pins.sync)
	);

	// enabled level wake sources, seen on the clock
	assign wake_sync = (!pins.ext_irq_0_n && i_ext_irq_en[0])
		|| (!pins.ext_irq_1_n && i_ext_irq_en[1])
		|| (pins.kbd && i_kbd_irq_en);

	// no clock runs in power-down, so the raw pins must restart the oscillator
	assign wake_async = (!i_ext_irq_0_n && i_ext_irq_en[0])
		|| (!i_ext_irq_1_n && i_ext_irq_en[1])
		|| (i_kbd_irq && i_kbd_irq_en);

	assign o_s_axi_awready = !state_reg.aw_got && !state_reg.bvalid;
	assign o_s_axi_wready = !state_reg.w_got && !state_reg.bvalid;
	assign o_s_axi_arready = !state_reg.rvalid;
	assign aw_hs = i_s_axi_awvalid && o_s_axi_awready;
	assign w_hs = i_s_axi_wvalid && o_s_axi_wready;
	assign ar_hs = i_s_axi_arvalid && o_s_axi_arready;
	assign do_write = state_reg.aw_got && state_reg.w_got && !state_reg.bvalid;
	assign wr_sel = decode_reg(state_reg.aw_addr);

	always_comb begin
		state_next = state_reg;

		// write channel capture, address and data in either order
		if (aw_hs) begin
			state_next.aw_got = 1'b1;
			state_next.aw_addr = i_s_axi_awaddr;
		end
		if (w_hs) begin
			state_next.w_got = 1'b1;
			state_next.w_data = i_s_axi_wdata;
			state_next.w_strb = i_s_axi_wstrb;
		end
		if (state_reg.bvalid && i_s_axi_bready) begin
			state_next.bvalid = 1'b0;
		end

		// read channel
		if (state_reg.rvalid && i_s_axi_rready) begin
			state_next.rvalid = 1'b0;
		end
		if (ar_hs) begin
			state_next.rvalid = 1'b1;
			state_next.rdata = 32'h0;
			state_next.rresp = IPD_RESP_OKAY;
			unique case (decode_reg(i_s_axi_araddr))
				IPD_SEL_POWER_CONTROL_REGISTER: begin
					state_next.rdata[3:0] = state_reg.power_control_register;
				end
				IPD_SEL_STAT: begin
					state_next.rdata[IPD_STAT_MODE_LSB +: 5] = state_reg.mode;
					state_next.rdata[IPD_STAT_RAMBLK_BIT] = state_reg.ram_block;
				end
				IPD_SEL_NONE: begin
					state_next.rresp = IPD_RESP_SLVERR;
				end
				default: begin
					state_next.rresp = IPD_RESP_SLVERR;
				end
			endcase
		end

		// mode sequencing; only the idle wake clears a register bit (idle) here
		unique case (state_reg.mode)
			IPD_ST_RUN: begin
				if (i_instr_done && state_reg.power_control_register[IPD_PD_BIT]) begin
					state_next.mode = IPD_ST_PD;
				end else if (i_instr_done && state_reg.power_control_register[IPD_IDLE_BIT]) begin
					state_next.mode = IPD_ST_IDLE;
				end
			end
			IPD_ST_IDLE: begin
				if (i_irq_pending) begin
					state_next.power_control_register[IPD_IDLE_BIT] = 1'b0;
					state_next.mode = IPD_ST_RUN;
				end
			end
			IPD_ST_PD: begin
				if (wake_sync) begin
					state_next.mode = IPD_ST_STAB;
					state_next.stab_cnt = 16'h0000;
				end
			end
			IPD_ST_STAB: begin
				// clocks stay off until the oscillator has settled
				if (state_reg.stab_cnt == STAB_LAST) begin
					state_next.mode = IPD_ST_HOLD;
				end else begin
					state_next.stab_cnt = state_reg.stab_cnt + 16'h0001;
				end
			end
			IPD_ST_HOLD: begin
				// execution waits for the wake level to be released
				if (!wake_sync) begin
					state_next.mode = IPD_ST_RUN;
				end
			end
			default: begin
				state_next.mode = IPD_ST_RUN;
			end
		endcase

		// both bits cleared on entering power-down wake; idle must not follow
		if (state_reg.mode == IPD_ST_PD && wake_sync) begin
			state_next.power_control_register[IPD_PD_BIT] = 1'b0;
			state_next.power_control_register[IPD_IDLE_BIT] = 1'b0;
		end
		if (i_irq_pending) begin
			state_next.power_control_register[IPD_PD_BIT] = 1'b0;
		end

		// reset pin wake: brief run with ram fenced off until internal reset
		if (pins.rst && state_reg.mode != IPD_ST_RUN) begin
			state_next.mode = IPD_ST_RUN;
			state_next.power_control_register[IPD_IDLE_BIT] = 1'b0;
			state_next.power_control_register[IPD_PD_BIT] = 1'b0;
			state_next.ram_block = 1'b1;
		end else if (pins.rst) begin
			state_next.power_control_register[IPD_PD_BIT] = 1'b0;
			state_next.power_control_register[IPD_IDLE_BIT] = 1'b0;
		end

		// software write last, so a set wins over a same-cycle hardware clear
		if (do_write) begin
			state_next.aw_got = 1'b0;
			state_next.w_got = 1'b0;
			state_next.bvalid = 1'b1;
			state_next.bresp = IPD_RESP_OKAY;
			unique case (wr_sel)
				IPD_SEL_POWER_CONTROL_REGISTER: begin
					if (state_reg.w_strb[0]) begin
						state_next.power_control_register = state_reg.w_data[3:0];
					end
				end
				IPD_SEL_STAT: begin
					state_next.bresp = IPD_RESP_OKAY;
				end
				IPD_SEL_NONE: begin
					state_next.bresp = IPD_RESP_SLVERR;
				end
				default: begin
					state_next.bresp = IPD_RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_reg.mode <= IPD_ST_RUN;
			state_reg.power_control_register <= IPD_POWER_CONTROL_REGISTER_RST;
			state_reg.ram_block <= 1'b0;
			state_reg.stab_cnt <= 16'h0000;
			state_reg.aw_got <= 1'b0;
			state_reg.aw_addr <= '0;
			state_reg.w_got <= 1'b0;
			state_reg.w_data <= 32'h0;
			state_reg.w_strb <= 4'h0;
			state_reg.bvalid <= 1'b0;
			state_reg.bresp <= IPD_RESP_OKAY;
			state_reg.rvalid <= 1'b0;
			state_reg.rdata <= 32'h0;
			state_reg.rresp <= IPD_RESP_OKAY;
		end else begin
			state_reg <= state_next;
		end
	end

	assign o_s_axi_bvalid = state_reg.bvalid;
	assign o_s_axi_bresp = state_reg.bresp;
	assign o_s_axi_rvalid = state_reg.rvalid;
	assign o_s_axi_rdata = state_reg.rdata;
	assign o_s_axi_rresp = state_reg.rresp;

	// raw reset pin acts on the gates at once, ahead of the synchroniser
	assign o_cpu_clk_en = (state_reg.mode == IPD_ST_RUN) || i_rst_pin;
	assign o_periph_clk_en = (state_reg.mode == IPD_ST_RUN)
		|| (state_reg.mode == IPD_ST_IDLE)
		|| (state_reg.mode == IPD_ST_HOLD) || i_rst_pin;
	assign o_osc_en = (state_reg.mode != IPD_ST_PD) || wake_async || i_rst_pin;
	assign o_ram_block = state_reg.ram_block;
	assign o_power_control_register = state_reg.power_control_register;

	// pin conditions per mode
	always_comb begin
		o_ports_high = !i_reset_n;
		o_port0_float = !i_reset_n;
		o_ale = i_ale_core;
		o_program_store_strobe_n = i_program_store_strobe_n_core;
		if (!i_reset_n) begin
			o_ale = 1'b1;
			o_program_store_strobe_n = 1'b1;
		end else if (state_reg.mode == IPD_ST_IDLE) begin
			o_ale = 1'b1;
			o_program_store_strobe_n = 1'b1;
			o_port0_float = i_ext_code;
		end else if (state_reg.mode != IPD_ST_RUN) begin
			o_ale = 1'b0;
			o_program_store_strobe_n = 1'b0;
			o_port0_float = i_ext_code;
		end
	end

endmodule

// ### ipd_power_ctrl_sva.sv
`timescale 1ns/10ps
module ipd_power_ctrl_sva (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic o_s_axi_awready,
	input wire logic o_s_axi_wready,
	input wire logic i_instr_done,
	input wire logic i_irq_pending,
	input wire logic [1:0] i_ext_irq_en,
	input wire logic i_ext_code,
	input wire logic i_ext_irq_0_n,
	input wire logic i_rst_pin,
	input wire logic o_cpu_clk_en,
	input wire logic o_periph_clk_en,
	input wire logic o_osc_en,
	input wire logic o_ram_block,
	input wire logic o_port0_float,
	input wire logic o_ports_high,
	input wire logic o_ale,
	input wire logic o_program_store_strobe_n,
	input wire logic [3:0] o_power_control_register
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	sequence s_run_go;
		i_instr_done && o_cpu_clk_en && !i_rst_pin;
	endsequence
	sequence s_idle;
		!o_cpu_clk_en && o_periph_clk_en && o_ale;
	endsequence
	chk_idle_entry: assert property (s_run_go ##0 (o_power_control_register[0] && !o_power_control_register[1]) |=>
		i_rst_pin || (!o_cpu_clk_en && o_periph_clk_en)) else $error("idle entry");
	chk_pd_entry: assert property (s_run_go ##0 o_power_control_register[1] |=>
		i_rst_pin || !(o_cpu_clk_en || o_periph_clk_en || o_ale)) else $error("pd entry");
	chk_idle_wake: assert property (s_idle ##0 (i_irq_pending && !i_rst_pin) |=>
		o_cpu_clk_en && !o_power_control_register[0]) else $error("idle wake");
	chk_pd_clear: assert property (i_irq_pending && o_s_axi_awready && o_s_axi_wready |=>
		!o_power_control_register[1]) else $error("pd clear");
	chk_rst_clocks: assert property (i_rst_pin |->
		o_cpu_clk_en && o_periph_clk_en && o_osc_en) else $error("reset pin clocks");
	chk_pd_freeze: assert property (!o_osc_en |-> !(o_cpu_clk_en || o_periph_clk_en
		|| o_ale || o_program_store_strobe_n)) else $error("pd freeze");
	chk_wake_osc: assert property (!i_ext_irq_0_n && i_ext_irq_en[0] |-> o_osc_en)
		else $error("wake osc");
	chk_port0_mode: assert property (!o_cpu_clk_en && !i_rst_pin |->
		o_port0_float == i_ext_code) else $error("port0");
	chk_ram_hold: assert property (o_ram_block |=> o_ram_block) else $error("ram block");
	chk_ports_run: assert property (!o_ports_high) else $error("ports high");
endmodule
bind ipd_power_ctrl ipd_power_ctrl_sva u_sva (.*);

// ### ipd_core_model.sv
`timescale 1ns/10ps
module ipd_core_model (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_cpu_clk_en,
	input wire logic i_step,
	input wire logic i_irq,
	output logic o_instr_done,
	output logic o_irq_pending,
	output logic o_ale,
	output logic o_strobe_n
);
	// a frozen core retires nothing; strobes toggle so stale levels show
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_instr_done <= 1'h0;
			o_irq_pending <= 1'h0;
			o_ale <= 1'h0;
			o_strobe_n <= 1'h0;
		end else begin
			o_instr_done <= i_step && i_cpu_clk_en;
			o_irq_pending <= i_irq;
			o_ale <= i_cpu_clk_en ? !o_ale : o_ale;
			o_strobe_n <= !o_ale;
		end
	end
endmodule

// ### ipd_power_ctrl_tb_top.sv
`timescale 1ns/10ps
module ipd_power_ctrl_tb_top;
	import ipd_pkg::*;
	logic i_mclk = 1'h0, i_reset_n = 1'h0;
	logic [7:0] i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00;
	logic [31:0] i_s_axi_wdata = 32'h0, o_s_axi_rdata, d;
	logic [3:0] i_s_axi_wstrb = 4'hF, o_power_control_register;
	logic i_s_axi_awvalid = 1'h0, i_s_axi_wvalid = 1'h0, i_s_axi_bready = 1'h0;
	logic i_s_axi_arvalid = 1'h0, i_s_axi_rready = 1'h0;
	logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
	logic [1:0] o_s_axi_bresp, o_s_axi_rresp, r, i_ext_irq_en = 2'h3;
	logic i_instr_done, i_irq_pending, i_ale_core, i_program_store_strobe_n_core;
	logic i_kbd_irq_en = 1'h1, i_ext_code = 1'h0, i_ext_irq_0_n = 1'h1, i_ext_irq_1_n = 1'h1;
	logic i_kbd_irq = 1'h0, i_rst_pin = 1'h0, step = 1'h0, irq = 1'h0;
	logic o_cpu_clk_en, o_periph_clk_en, o_osc_en, o_ram_block, o_port0_float, o_ports_high;
	logic o_ale, o_program_store_strobe_n;
	integer fails = 0, n_tests = 0, seed = 32'h9CD3ECD6;
	ipd_power_ctrl #(.OSC_STABLE_CYC(4)) uut (.*);
	ipd_core_model core (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_cpu_clk_en(o_cpu_clk_en),
		.i_step(step), .i_irq(irq), .o_instr_done(i_instr_done), .o_irq_pending(i_irq_pending),
		.o_ale(i_ale_core), .o_strobe_n(i_program_store_strobe_n_core));
	initial begin
		forever #5 i_mclk = ~i_mclk;
	end
	function automatic logic [31:0] f_power_control_register(input logic [31:0] v);
		return v & 32'hC;
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge i_mclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
		logic ga, gw, ta, tw;
		@(posedge i_mclk);
		i_s_axi_awaddr <= a;
		i_s_axi_wdata <= v;
		i_s_axi_wstrb <= s;
		i_s_axi_awvalid <= 1'h1;
		i_s_axi_wvalid <= 1'h1;
		i_s_axi_bready <= 1'h1;
		ga = 1'h0;
		gw = 1'h0;
		while (!(ga && gw)) begin
			@(negedge i_mclk);
			ta = o_s_axi_awready && !ga;
			tw = o_s_axi_wready && !gw;
			@(posedge i_mclk);
			if (ta) i_s_axi_awvalid <= 1'h0;
			if (tw) i_s_axi_wvalid <= 1'h0;
			ga = ga || ta;
			gw = gw || tw;
		end
		do begin
			@(negedge i_mclk);
			ta = o_s_axi_bvalid;
			r = o_s_axi_bresp;
			@(posedge i_mclk);
		end while (!ta);
		i_s_axi_bready <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a);
		logic ok;
		@(posedge i_mclk);
		i_s_axi_araddr <= a;
		i_s_axi_arvalid <= 1'h1;
		i_s_axi_rready <= 1'h1;
		do begin
			@(negedge i_mclk);
			ok = o_s_axi_arready;
			@(posedge i_mclk);
		end while (!ok);
		i_s_axi_arvalid <= 1'h0;
		do begin
			@(negedge i_mclk);
			ok = o_s_axi_rvalid;
			d = o_s_axi_rdata;
			r = o_s_axi_rresp;
			@(posedge i_mclk);
		end while (!ok);
		i_s_axi_rready <= 1'h0;
	endtask
	task automatic mode_is(input ipd_mode_e m);
		rd(IPD_STAT_OFFS);
		chk("mode", 32'(m), d & 32'h1F);
	endtask
	task automatic step_core;
		@(posedge i_mclk);
		step <= 1'h1;
		@(posedge i_mclk);
		step <= 1'h0;
		cyc(2);
	endtask
	task automatic set_wake(input int s, input logic on);
		i_ext_irq_0_n <= !(on && s == 0);
		i_ext_irq_1_n <= !(on && s == 1);
		i_kbd_irq <= on && s == 2;
	endtask
	task automatic stop_test;
		$display("tests %0d fails %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		#100000;
		fails++;
		stop_test;
	end
	initial begin
		logic [31:0] v;
		#2;
		chk("rst_pins", 32'hF, {o_ports_high, o_port0_float, o_ale, o_program_store_strobe_n});
		repeat (3) @(posedge i_mclk);
		i_reset_n <= 1'h1;
		chk("power_control_register_rst", 32'(IPD_POWER_CONTROL_REGISTER_RST), o_power_control_register);
		mode_is(IPD_ST_RUN);
		for (int i = 0; i < 4; i++) begin
			v = $random(seed) & 32'hFFFFFFFC;
			wr(IPD_POWER_CONTROL_REGISTER_OFFS, v, 4'hF);
			rd(IPD_POWER_CONTROL_REGISTER_OFFS);
			chk("power_control_register_rd", f_power_control_register(v), d & 32'hF);
		end
		wr(IPD_POWER_CONTROL_REGISTER_OFFS, 32'h3, 4'h0);
		chk("power_control_register_strb", f_power_control_register(v), o_power_control_register);
		wr(8'h10, 32'h0, 4'hF);
		chk("bresp", 32'(IPD_RESP_SLVERR), r);
		rd(8'h10);
		chk("rresp", 32'(IPD_RESP_SLVERR), r);
		chk("rdata", 32'h0, d);
		wr(IPD_STAT_OFFS, 32'hFF, 4'hF);
		chk("stat_wr", 32'(IPD_RESP_OKAY), r);
		mode_is(IPD_ST_RUN);
		$display("test registers done");
		wr(IPD_POWER_CONTROL_REGISTER_OFFS, 32'h2, 4'hF);
		irq <= 1'h1;
		cyc(3);
		chk("pd_irq", 32'h0, o_power_control_register[1]);
		@(posedge i_mclk);
		irq <= 1'h0;
		i_ext_code <= 1'h1;
		wr(IPD_POWER_CONTROL_REGISTER_OFFS, 32'h5, 4'hF);
		step_core;
		chk("idle_clk", 32'h1, {o_cpu_clk_en, o_periph_clk_en});
		chk("idle_pins", 32'h7, {o_ale, o_program_store_strobe_n, o_port0_float});
		mode_is(IPD_ST_IDLE);
		step_core;
		chk("idle_keep", 32'h5, o_power_control_register);
		@(posedge i_mclk);
		irq <= 1'h1;
		cyc(3);
		chk("idle_wake", 32'h14, {o_cpu_clk_en, o_power_control_register});
		@(posedge i_mclk);
		irq <= 1'h0;
		$display("test idle done");
		for (int s = 0; s < 3; s++) begin
			wr(IPD_POWER_CONTROL_REGISTER_OFFS, 32'hB, 4'hF);
			step_core;
			mode_is(IPD_ST_PD);
			chk("pd_clk", 32'h0, {o_cpu_clk_en, o_periph_clk_en, o_osc_en, o_ale});
			@(posedge i_mclk);
			set_wake(s, 1'h1);
			cyc(1);
			chk("wake_osc", 32'h1, o_osc_en);
			cyc(20);
			chk("hold", 32'h28, {o_cpu_clk_en, o_periph_clk_en, o_ale, o_power_control_register});
			@(posedge i_mclk);
			set_wake(s, 1'h0);
			cyc(8);
			chk("resume", 32'h1, o_cpu_clk_en);
			mode_is(IPD_ST_RUN);
		end
		$display("test powerdown done");
		i_ext_irq_en <= 2'h0;
		wr(IPD_POWER_CONTROL_REGISTER_OFFS, 32'h2, 4'hF);
		step_core;
		@(posedge i_mclk);
		i_ext_irq_0_n <= 1'h0;
		cyc(10);
		chk("no_wake", 32'h0, {o_cpu_clk_en, o_osc_en});
		@(posedge i_mclk);
		i_ext_irq_0_n <= 1'h1;
		i_rst_pin <= 1'h1;
		cyc(1);
		chk("rst_clk", 32'h7, {o_cpu_clk_en, o_periph_clk_en, o_osc_en});
		cyc(4);
		chk("rst_pd", 32'h10, {o_ram_block, o_power_control_register});
		mode_is(IPD_ST_RUN);
		chk("stat_ram", 32'h1, d[IPD_STAT_RAMBLK_BIT]);
		@(posedge i_mclk);
		i_rst_pin <= 1'h0;
		i_reset_n <= 1'h0;
		i_ext_irq_en <= 2'h3;
		cyc(1);
		chk("ram_clr", 32'h0, o_ram_block);
		@(posedge i_mclk);
		i_reset_n <= 1'h1;
		wr(IPD_POWER_CONTROL_REGISTER_OFFS, 32'h1, 4'hF);
		step_core;
		@(posedge i_mclk);
		i_rst_pin <= 1'h1;
		cyc(1);
		chk("idle_rst", 32'h1, o_cpu_clk_en);
		cyc(4);
		chk("idle_rst_bit", 32'h10, {o_ram_block, o_power_control_register});
		@(posedge i_mclk);
		i_rst_pin <= 1'h0;
		$display("test reset pin done");
		stop_test;
	end
endmodule
